// *** design/uop_defines.svh ***
// register offsets, field positions, reset values and timing figures
`ifndef UOP_DEFINES_SVH
`define UOP_DEFINES_SVH

// register byte offsets on the plain register port
`define UOP_ADDR_W 4
`define UOP_OFS_LINE 4'h0
`define UOP_OFS_POWER 4'h4
`define UOP_OFS_IRQ 4'h8
`define UOP_OFS_ERREN 4'hc

// line control fields
`define UOP_LC_DP_PU 7
`define UOP_LC_DM_PU 6
`define UOP_LC_DP_PD 5
`define UOP_LC_DM_PD 4
`define UOP_LC_PWR_ON 3
`define UOP_LC_SW_EN 2
`define UOP_LC_CHG 1
`define UOP_LC_DIS 0

// power control fields
`define UOP_PC_ACT_PND 7
`define UOP_PC_GUARD 4
`define UOP_PC_BUSY 3
`define UOP_PC_SUSP 1
`define UOP_PC_OP_EN 0

// interrupt flag fields
`define UOP_IF_STALL 7
`define UOP_IF_ATTACH 6
`define UOP_IF_RESUME 5
`define UOP_IF_IDLE 4
`define UOP_IF_TOKEN 3
`define UOP_IF_SOF 2
`define UOP_IF_ERR 1
`define UOP_IF_RESET 0
`define UOP_IF_W1C_MASK 8'hfd

// reset values and read fill
`define UOP_BYTE_ZERO 8'h00
`define UOP_WORD_ZERO 32'h0000_0000
`define UOP_UPPER_ZERO 24'h00_0000

// synchroniser reset level: idle J, so release shows no false line change
`define UOP_LINE_IDLE 2'h2

// timing
`define UOP_CLK_MHZ 100
`define UOP_IDLE_TIME_US 3000
`define UOP_RESUME_TIME_NS 2500
`define UOP_SHUTDOWN_CYCLES 16

`endif

// *** design/uop_pkg.sv ***
// shared types of the otg power and interrupt register bank
`default_nettype none

package uop_pkg;

  typedef logic [7:0] uop_byte_t;

  // full-speed line states, {dplus, dminus}
  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_K = 2'b01,
    LS_J = 2'b10,
    LS_SE1 = 2'b11
  } uop_line_t;

endpackage

`default_nettype wire

// *** design/uop_line_timer.sv ***
// qualifier: flags a condition once it has held for a set number of cycles
`timescale 1ns/10ps
`default_nettype none

module uop_line_timer #(
  parameter int CYCLES = 250,
  parameter int CNT_W = 20
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // condition in, one-cycle hit out
  input wire logic cond,
  output logic hit
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic fired_r;
  logic fired_nxt;
  logic hit_nxt;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  // refuse a count the counter cannot hold
  if (CYCLES < 1 || CYCLES > (2 ** CNT_W))
  begin : g_bad
    $error("uop_line_timer: CYCLES does not fit CNT_W");
  end

  // count only while the condition stays; fire once per stable run
  always_comb
  begin
    cnt_nxt = cnt_r;
    fired_nxt = fired_r;
    hit_nxt = 1'b0;
    if (!cond)
    begin
      cnt_nxt = '0;
      fired_nxt = 1'b0;
    end
    else if (!fired_r)
    begin
      if (cnt_r == LAST)
      begin
        hit_nxt = 1'b1;
        fired_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
      fired_r <= 1'b0;
      hit <= 1'b0;
    end
    else if (clkEn)
    begin
      cnt_r <= cnt_nxt;
      fired_r <= fired_nxt;
      hit <= hit_nxt;
    end
  end

endmodule

`default_nettype wire

// *** design/uop_regs.sv ***
// otg line control, power control and interrupt flag register bank
//----------------------------------------------------------------------
// How it works
// - line-control D+ pull-up bit one connects D+ pull-up, zero disconnects
// - line-control D- pull-up bit one connects D- pull-up, zero disconnects
// - D+ pull-down bit one connects D+ pull-down, zero disconnects it
// - D- pull-down bit one connects D- pull-down, zero disconnects it
// - software-control bit selects register values, else engine drives resistors
// - supply power-on bit drives the supply power output
// - supply charge bit applies the charging pull-up to the supply line
// - supply discharge bit applies the discharging pull-down to the supply
// - upper bits read zero, writes ignored, implemented bits reset zero
// - activity-pending flag set on activity while suspended, held until suspend clears
// - sleep guard blocks sleep on bus activity or pending notification
// - busy reads one while on or still shutting down after disable
// - suspend gates the usb clock and puts transceiver in low power
// - operation enable zero holds clock, transceiver and analog outputs inactive and frees pins
// - hardware sets low-byte flags; writing one clears; flags hold
// - error summary reflects enabled errors only; writes cannot clear it
// - clearing token-done flag advances the transaction status fifo
// - idle flag set after bus idle for 3 ms or more
// - resume flag set after K state held for 2.5 us
//----------------------------------------------------------------------
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "uop_defines.svh"

module uop_regs #(
  parameter int IDLE_CYCLES =
    (`UOP_IDLE_TIME_US * `UOP_CLK_MHZ + 0),
  parameter int SHUTDOWN_CYCLES = `UOP_SHUTDOWN_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // register port
  input wire logic [`UOP_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // data line pins, asynchronous
  input wire logic dplusPin,
  input wire logic dminusPin,
  // serial engine side
  input wire logic hostMode,
  input wire logic hwDplusPullup,
  input wire logic hwDminusPullup,
  input wire logic hwDplusPulldown,
  input wire logic hwDminusPulldown,
  input wire logic stallEvt,
  input wire logic attachEvt,
  input wire logic tokenDoneEvt,
  input wire logic frameStartEvt,
  input wire logic busResetEvt,
  input wire logic detachEvt,
  input wire logic [7:0] errStatus,
  input wire logic engineBusy,
  output logic tokenFifoAdvance,
  // resistor and supply controls
  output logic dplusPullupOn,
  output logic dminusPullupOn,
  output logic dplusPulldownOn,
  output logic dminusPulldownOn,
  output logic supplyPowerOn,
  output logic supplyChargeOn,
  output logic supplyDischargeOn,
  // power management
  output logic usbClkRun,
  output logic xcvrLowPower,
  output logic usbPinsOwned,
  output logic analogOn,
  output logic sleepBlock
);

  localparam int RESUME_CYCLES =
    (`UOP_RESUME_TIME_NS * `UOP_CLK_MHZ + 999) / 1000;
  localparam int OFF_W = 8;

  // refuse counts the logic cannot serve
  if (SHUTDOWN_CYCLES < 1 || SHUTDOWN_CYCLES > 255)
  begin : g_bad_off
    $error("uop_regs: SHUTDOWN_CYCLES out of range");
  end

  // address decode used by both the read and the write path
  function automatic logic hitOfs(input logic [`UOP_ADDR_W-1:0] a,
                                  input logic [`UOP_ADDR_W-1:0] ofs);
    hitOfs = (a == ofs);
  endfunction

  //--------------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------------
  logic [1:0] pinMeta_r;
  logic [1:0] pinSync_r;
  logic [1:0] pinPrev_r;
  uop_pkg::uop_line_t lineNow;

  // two flops before anything looks at the pins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pinMeta_r <= `UOP_LINE_IDLE;
      pinSync_r <= `UOP_LINE_IDLE;
      pinPrev_r <= `UOP_LINE_IDLE;
    end
    else if (clkEn)
    begin
      pinMeta_r <= {dplusPin, dminusPin};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  assign lineNow = uop_pkg::uop_line_t'(pinSync_r);

  //--------------------------------------------------------------------
  // idle and resume qualifiers
  //--------------------------------------------------------------------
  logic idleHit;
  logic resumeHit;
  logic lineActive;

  assign lineActive = (pinSync_r != pinPrev_r);

  uop_line_timer #(
    .CYCLES(IDLE_CYCLES),
    .CNT_W(20)
  ) u_idle (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clkEn(clkEn),
    .cond(lineNow == uop_pkg::LS_J),
    .hit(idleHit)
  );

  uop_line_timer #(
    .CYCLES(RESUME_CYCLES),
    .CNT_W(9)
  ) u_resume (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clkEn(clkEn),
    .cond(lineNow == uop_pkg::LS_K),
    .hit(resumeHit)
  );

  //--------------------------------------------------------------------
  // register state
  //--------------------------------------------------------------------
  uop_pkg::uop_byte_t lineCtrl_r;
  uop_pkg::uop_byte_t lineCtrl_nxt;
  uop_pkg::uop_byte_t errEn_r;
  uop_pkg::uop_byte_t errEn_nxt;
  uop_pkg::uop_byte_t irq_r;
  uop_pkg::uop_byte_t irq_nxt;
  logic guard_r;
  logic guard_nxt;
  logic susp_r;
  logic susp_nxt;
  logic opEn_r;
  logic opEn_nxt;
  logic actPnd_r;
  logic actPnd_nxt;
  logic errSum_r;
  logic errSum_nxt;
  logic [OFF_W-1:0] offCnt_r;
  logic [OFF_W-1:0] offCnt_nxt;
  logic busy;
  uop_pkg::uop_byte_t irqSet;
  uop_pkg::uop_byte_t irqClr;
  logic wrLine;
  logic wrPower;
  logic wrIrq;
  logic wrErrEn;

  // write decode; upper data bits are never looked at
  assign wrLine = regWr && hitOfs(regAddr, `UOP_OFS_LINE);
  assign wrPower = regWr && hitOfs(regAddr, `UOP_OFS_POWER);
  assign wrIrq = regWr && hitOfs(regAddr, `UOP_OFS_IRQ);
  assign wrErrEn = regWr && hitOfs(regAddr, `UOP_OFS_ERREN);

  // busy covers the drain time after a disable
  assign busy = opEn_r || engineBusy || (offCnt_r != '0);

  // hardware events into the flag byte; bit 0 meaning follows the role
  always_comb
  begin
    irqSet = `UOP_BYTE_ZERO;
    irqSet[`UOP_IF_STALL] = stallEvt;
    irqSet[`UOP_IF_ATTACH] = attachEvt;
    irqSet[`UOP_IF_RESUME] = resumeHit;
    irqSet[`UOP_IF_IDLE] = idleHit;
    irqSet[`UOP_IF_TOKEN] = tokenDoneEvt;
    irqSet[`UOP_IF_SOF] = frameStartEvt;
    irqSet[`UOP_IF_RESET] = hostMode ? detachEvt : busResetEvt;
  end

  // write-one-to-clear; the summary bit is outside the mask
  assign irqClr = wrIrq ? (regWrData[7:0] & `UOP_IF_W1C_MASK)
                        : `UOP_BYTE_ZERO;

  // next values of every software-visible bit
  always_comb
  begin
    lineCtrl_nxt = lineCtrl_r;
    errEn_nxt = errEn_r;
    guard_nxt = guard_r;
    susp_nxt = susp_r;
    opEn_nxt = opEn_r;
    offCnt_nxt = offCnt_r;
    if (wrLine)
    begin
      lineCtrl_nxt = regWrData[7:0];
    end
    if (wrErrEn)
    begin
      errEn_nxt = regWrData[7:0];
    end
    // busy itself is status, so its written value is dropped
    if (wrPower)
    begin
      guard_nxt = regWrData[`UOP_PC_GUARD];
      susp_nxt = regWrData[`UOP_PC_SUSP];
      opEn_nxt = regWrData[`UOP_PC_OP_EN];
    end
    // start draining on the falling edge of the enable
    if (opEn_r && !opEn_nxt)
    begin
      offCnt_nxt = OFF_W'(SHUTDOWN_CYCLES);
    end
    else if (offCnt_r != '0)
    begin
      offCnt_nxt = offCnt_r - OFF_W'(1);
    end
    // set wins over clear
    irq_nxt = (irq_r & ~irqClr) | irqSet;
    // the summary is only ever driven by enabled errors
    errSum_nxt = |(errStatus & errEn_r);
    // pending from activity seen while suspended until suspend clears
    actPnd_nxt = actPnd_r;
    if (!susp_r)
    begin
      actPnd_nxt = 1'b0;
    end
    if (susp_r && lineActive)
    begin
      actPnd_nxt = 1'b1;
    end
  end

  // register bank flops, all zero at reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      lineCtrl_r <= `UOP_BYTE_ZERO;
      errEn_r <= `UOP_BYTE_ZERO;
      irq_r <= `UOP_BYTE_ZERO;
      guard_r <= 1'b0;
      susp_r <= 1'b0;
      opEn_r <= 1'b0;
      actPnd_r <= 1'b0;
      errSum_r <= 1'b0;
      offCnt_r <= '0;
    end
    else if (clkEn)
    begin
      lineCtrl_r <= lineCtrl_nxt;
      errEn_r <= errEn_nxt;
      irq_r <= irq_nxt;
      guard_r <= guard_nxt;
      susp_r <= susp_nxt;
      opEn_r <= opEn_nxt;
      actPnd_r <= actPnd_nxt;
      errSum_r <= errSum_nxt;
      offCnt_r <= offCnt_nxt;
    end
  end

  //--------------------------------------------------------------------
  // read path
  //--------------------------------------------------------------------
  logic [31:0] rdData_nxt;
  uop_pkg::uop_byte_t rdByte;

  // unmapped addresses and the upper bits read zero
  always_comb
  begin
    rdByte = `UOP_BYTE_ZERO;
    if (hitOfs(regAddr, `UOP_OFS_LINE))
    begin
      rdByte = lineCtrl_r;
    end
    else if (hitOfs(regAddr, `UOP_OFS_POWER))
    begin
      rdByte[`UOP_PC_ACT_PND] = actPnd_r;
      rdByte[`UOP_PC_GUARD] = guard_r;
      rdByte[`UOP_PC_BUSY] = busy;
      rdByte[`UOP_PC_SUSP] = susp_r;
      rdByte[`UOP_PC_OP_EN] = opEn_r;
    end
    else if (hitOfs(regAddr, `UOP_OFS_IRQ))
    begin
      rdByte = irq_r;
      rdByte[`UOP_IF_ERR] = errSum_r;
    end
    else if (hitOfs(regAddr, `UOP_OFS_ERREN))
    begin
      rdByte = errEn_r;
    end
    // data stands only in the cycle after the strobe
    rdData_nxt = regRd ? {`UOP_UPPER_ZERO, rdByte} : `UOP_WORD_ZERO;
  end

  //--------------------------------------------------------------------
  // output controls
  //--------------------------------------------------------------------
  logic [3:0] resSel;
  logic [12:0] outs_nxt;

  // resistor source: software value or engine; registered, so one cycle
  // behind the write, which the analog switches never notice
  always_comb
  begin
    if (lineCtrl_r[`UOP_LC_SW_EN])
    begin
      resSel = {lineCtrl_r[`UOP_LC_DP_PU], lineCtrl_r[`UOP_LC_DM_PU],
                lineCtrl_r[`UOP_LC_DP_PD], lineCtrl_r[`UOP_LC_DM_PD]};
    end
    else
    begin
      resSel = {hwDplusPullup, hwDminusPullup,
                hwDplusPulldown, hwDminusPulldown};
    end
    outs_nxt[12] = resSel[3];
    outs_nxt[11] = resSel[2];
    outs_nxt[10] = resSel[1];
    outs_nxt[9] = resSel[0];
    outs_nxt[8] = lineCtrl_r[`UOP_LC_PWR_ON];
    outs_nxt[7] = lineCtrl_r[`UOP_LC_CHG];
    outs_nxt[6] = lineCtrl_r[`UOP_LC_DIS];
    outs_nxt[5] = opEn_r && !susp_r;
    outs_nxt[4] = susp_r || !opEn_r;
    outs_nxt[3] = opEn_r;
    outs_nxt[2] = opEn_r && !susp_r;
    outs_nxt[1] = guard_r && (lineActive || actPnd_r);
    outs_nxt[0] = irqClr[`UOP_IF_TOKEN] && irq_r[`UOP_IF_TOKEN];
  end

  // every output straight from a flop
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData <= `UOP_WORD_ZERO;
      dplusPullupOn <= 1'b0;
      dminusPullupOn <= 1'b0;
      dplusPulldownOn <= 1'b0;
      dminusPulldownOn <= 1'b0;
      supplyPowerOn <= 1'b0;
      supplyChargeOn <= 1'b0;
      supplyDischargeOn <= 1'b0;
      usbClkRun <= 1'b0;
      xcvrLowPower <= 1'b1;
      usbPinsOwned <= 1'b0;
      analogOn <= 1'b0;
      sleepBlock <= 1'b0;
      tokenFifoAdvance <= 1'b0;
    end
    else if (clkEn)
    begin
      regRdData <= rdData_nxt;
      dplusPullupOn <= outs_nxt[12];
      dminusPullupOn <= outs_nxt[11];
      dplusPulldownOn <= outs_nxt[10];
      dminusPulldownOn <= outs_nxt[9];
      supplyPowerOn <= outs_nxt[8];
      supplyChargeOn <= outs_nxt[7];
      supplyDischargeOn <= outs_nxt[6];
      usbClkRun <= outs_nxt[5];
      xcvrLowPower <= outs_nxt[4];
      usbPinsOwned <= outs_nxt[3];
      analogOn <= outs_nxt[2];
      sleepBlock <= outs_nxt[1];
      tokenFifoAdvance <= outs_nxt[0];
    end
  end

endmodule

`default_nettype wire

// *** tb/uop_regs_assertions.sv ***
// concurrent checks on the otg power and interrupt register bank ports
`timescale 1ns/10ps
`default_nettype none
`include "uop_defines.svh"

module uop_regs_assertions (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // register port
  input wire logic [`UOP_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  // engine side
  input wire logic hwDplusPullup,
  input wire logic tokenFifoAdvance,
  // resistor, supply and power outputs
  input wire logic dplusPullupOn,
  input wire logic dminusPullupOn,
  input wire logic dplusPulldownOn,
  input wire logic dminusPulldownOn,
  input wire logic supplyPowerOn,
  input wire logic supplyChargeOn,
  input wire logic supplyDischargeOn,
  input wire logic usbClkRun,
  input wire logic xcvrLowPower
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  //--------------------------------------------------------------------
  // decoded write strobes
  //--------------------------------------------------------------------
  logic lineWr;
  logic powerWr;
  assign lineWr = regWr && clkEn && (regAddr == `UOP_OFS_LINE);
  assign powerWr = regWr && clkEn && (regAddr == `UOP_OFS_POWER);

  //--------------------------------------------------------------------
  // properties
  //--------------------------------------------------------------------
  // outputs settle one edge after the state, hence the depth of two
  a_rd_idle_zero: assert property (!$past(regRd && clkEn) |->
    regRdData == 32'h0000_0000) else $error("read data outside slot");
  a_upper_zero: assert property (regRdData[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (
    regRd && clkEn && regAddr[1:0] != 2'h0 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  a_sw_resistors: assert property (lineWr && regWrData[2] ##1 clkEn |=>
    {dplusPullupOn, dminusPullupOn, dplusPulldownOn, dminusPulldownOn}
    == $past(regWrData[7:4], 2)) else $error("resistors miss write");
  a_hw_resistor: assert property (lineWr && !regWrData[2] ##1 clkEn |=>
    dplusPullupOn == $past(hwDplusPullup))
    else $error("engine pull-up not followed");
  a_supply_ctrl: assert property (lineWr ##1 clkEn |=>
    {supplyPowerOn, supplyChargeOn, supplyDischargeOn}
    == $past({regWrData[3], regWrData[1:0]}, 2))
    else $error("supply outputs miss write");
  a_clock_gate: assert property (powerWr ##1 clkEn |=>
    usbClkRun == $past(regWrData[0] && !regWrData[1], 2))
    else $error("usb clock gate wrong");
  a_xcvr_low: assert property (powerWr ##1 clkEn |=>
    xcvrLowPower == $past(regWrData[1] || !regWrData[0], 2))
    else $error("transceiver power state wrong");
  a_token_cause: assert property (tokenFifoAdvance |->
    $past(regWr && clkEn && regAddr == `UOP_OFS_IRQ && regWrData[3]))
    else $error("fifo advance without token clear");
  a_token_pulse: assert property (tokenFifoAdvance |=> !tokenFifoAdvance)
    else $error("fifo advance longer than one cycle");

  // main scenarios
  c_sw_line: cover property (lineWr && regWrData[2] ##2 dplusPullupOn);
  c_token: cover property (tokenFifoAdvance);
  c_suspend: cover property (powerWr ##2 xcvrLowPower && !usbClkRun);
endmodule
`default_nettype wire

// *** tb/uop_cable_model.sv ***
// far-side cable model driving the two data lines
`timescale 1ns/10ps
`default_nettype none

module uop_cable_model (
  // clock
  input wire logic clk_sys,
  // far-side line command
  input wire logic drive,
  input wire uop_pkg::uop_line_t state,
  // local resistors
  input wire logic dplusPullupOn,
  input wire logic dplusPulldownOn,
  input wire logic dminusPullupOn,
  input wire logic dminusPulldownOn,
  // data lines
  output logic dplusPin,
  output logic dminusPin
);
  //--------------------------------------------------------------------
  // line levels
  //--------------------------------------------------------------------
  // an unpulled released line flips each cycle so no stale level
  // can pass for a stable bus state
  initial
  begin
    dplusPin = 1'b1;
    dminusPin = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    if (drive)
    begin
      dplusPin <= state[1];
      dminusPin <= state[0];
    end
    else
    begin
      dplusPin <= dplusPullupOn | (~dplusPulldownOn & ~dplusPin);
      dminusPin <= dminusPullupOn | (~dminusPulldownOn & ~dminusPin);
    end
  end
endmodule
`default_nettype wire

// *** tb/uop_regs_bench.sv ***
// self-checking bench for the otg power and interrupt register bank
`timescale 1ns/10ps
`default_nettype none
`include "uop_defines.svh"

module uop_regs_bench;
  localparam int IDLE_N = 20;
  localparam int DRAIN_N = 4;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic hostMode = 1'b0;
  logic [3:0] hwRes = 4'h0;
  logic [5:0] evt = 6'h00;
  logic [7:0] errStatus = 8'h00;
  logic engineBusy = 1'b0;
  logic drive = 1'b0;
  uop_pkg::uop_line_t lineSt = uop_pkg::LS_J;
  logic [31:0] regRdData;
  logic dplusPin, dminusPin, tokenFifoAdvance, sleepBlock;
  logic dplusPullupOn, dminusPullupOn, dplusPulldownOn, dminusPulldownOn;
  logic supplyPowerOn, supplyChargeOn, supplyDischargeOn;
  logic usbClkRun, xcvrLowPower, usbPinsOwned, analogOn;
  logic [7:0] lineOuts;
  logic [3:0] pwrOuts;
  int fail_count = 0;
  int comparisons = 0;
  // event slot, flag seen and host mode per flag case
  logic [5:0] evTab [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20,
    6'h10, 6'h20};
  logic [7:0] flTab [8] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h01, 8'h01,
    8'h00, 8'h00};
  logic hmTab [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  assign lineOuts = {dplusPullupOn, dminusPullupOn, dplusPulldownOn,
    dminusPulldownOn, supplyPowerOn, 1'b0, supplyChargeOn, supplyDischargeOn};
  assign pwrOuts = {usbClkRun, xcvrLowPower, usbPinsOwned, analogOn};

  //--------------------------------------------------------------------
  // design, far side and clock
  //--------------------------------------------------------------------
  uop_regs #(.IDLE_CYCLES(IDLE_N), .SHUTDOWN_CYCLES(DRAIN_N)) dut_u (
    .clk_sys, .nrst, .clkEn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .dplusPin, .dminusPin, .hostMode,
    .hwDplusPullup(hwRes[3]), .hwDminusPullup(hwRes[2]),
    .hwDplusPulldown(hwRes[1]), .hwDminusPulldown(hwRes[0]),
    .stallEvt(evt[0]), .attachEvt(evt[1]), .tokenDoneEvt(evt[2]),
    .frameStartEvt(evt[3]), .busResetEvt(evt[4]), .detachEvt(evt[5]),
    .errStatus, .engineBusy, .tokenFifoAdvance, .dplusPullupOn,
    .dminusPullupOn, .dplusPulldownOn, .dminusPulldownOn, .supplyPowerOn,
    .supplyChargeOn, .supplyDischargeOn, .usbClkRun, .xcvrLowPower,
    .usbPinsOwned, .analogOn, .sleepBlock);
  uop_cable_model cable_u (.clk_sys, .drive, .state(lineSt),
    .dplusPullupOn, .dplusPulldownOn, .dminusPullupOn, .dminusPulldownOn,
    .dplusPin, .dminusPin);
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  //--------------------------------------------------------------------
  // access tasks
  //--------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= 6'h00;
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  //--------------------------------------------------------------------
  // tests
  //--------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a < 16; a += 4)
      rd(a[3:0], 32'h0);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, 32'h0);
    rd(4'h0, 32'h0);
    $display("test reset and unmapped done");
    wr(4'h0, 32'hffff_ffff);
    rd(4'h0, 32'h0000_00ff);
    check({24'h0, lineOuts}, 32'hfb);
    wr(4'h0, 32'h0000_00a6);
    rd(4'h0, 32'h0000_00a6);
    check({24'h0, lineOuts}, 32'ha2);
    hwRes <= 4'b1001;
    wr(4'h0, 32'h0000_00f9);
    tick(2);
    check({24'h0, lineOuts}, 32'h99);
    hwRes <= 4'b0110;
    drive <= 1'b1; // settle the line before the sleep guard is armed
    tick(2);
    check({24'h0, lineOuts}, 32'h69);
    $display("test line control done");
    wr(4'h4, 32'hffff_ff11);
    rd(4'h4, 32'h0000_0019);
    check({27'h0, pwrOuts, sleepBlock}, 32'h16);
    wr(4'h4, 32'h0000_0013);
    tick(2);
    check({28'h0, pwrOuts}, 32'h6);
    lineSt <= uop_pkg::LS_K;
    tick(6);
    check({31'h0, sleepBlock}, 32'h1);
    rd(4'h4, 32'h0000_009b);
    lineSt <= uop_pkg::LS_J;
    wr(4'h4, 32'h0000_0001);
    lineSt <= uop_pkg::LS_K;
    tick(4);
    check({31'h0, sleepBlock}, 32'h0);
    rd(4'h4, 32'h0000_0009);
    lineSt <= uop_pkg::LS_J;
    wr(4'h4, 32'h0000_0000);
    rd(4'h4, 32'h0000_0008);
    check({28'h0, pwrOuts}, 32'h4);
    tick(DRAIN_N + 4);
    rd(4'h4, 32'h0);
    engineBusy <= 1'b1;
    rd(4'h4, 32'h0000_0008);
    engineBusy <= 1'b0;
    rd(4'h4, 32'h0);
    $display("test power control done");
    wr(4'h4, 32'h0000_0001);
    tick(IDLE_N); // let the current idle run fire before the sweep
    wr(4'h8, 32'h0000_00ff);
    rd(4'h8, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      hostMode <= hmTab[i];
      pulse(evTab[i]);
      rd(4'h8, {24'h0, flTab[i]});
      wr(4'h8, 32'h0);
      rd(4'h8, {24'h0, flTab[i]});
      wr(4'h8, {24'h0, flTab[i]});
      #1;
      check({31'h0, tokenFifoAdvance}, {31'h0, i == 2});
      rd(4'h8, 32'h0);
    end
    @(posedge clk_sys);
    evt <= 6'h01;
    regWr <= 1'b1;
    regAddr <= 4'h8;
    regWrData <= 32'h80;
    @(posedge clk_sys);
    evt <= 6'h00;
    regWr <= 1'b0;
    rd(4'h8, 32'h0000_0080);
    wr(4'h8, 32'h0000_0080);
    $display("test interrupt flags done");
    wr(4'hc, 32'h0000_0002);
    errStatus <= 8'h01;
    tick(2);
    rd(4'h8, 32'h0);
    errStatus <= 8'h02;
    tick(2);
    rd(4'h8, 32'h0000_0002);
    wr(4'h8, 32'h0000_0002);
    rd(4'h8, 32'h0000_0002);
    errStatus <= 8'h00;
    tick(2);
    rd(4'h8, 32'h0);
    $display("test error summary done");
    // a write under a low clock enable must not land
    clkEn <= 1'b0;
    wr(4'h0, 32'h0000_0004);
    clkEn <= 1'b1;
    rd(4'h0, 32'h0000_00f9);
    $display("test clock enable done");
    lineSt <= uop_pkg::LS_K;
    tick(260);
    rd(4'h8, 32'h0000_0020);
    lineSt <= uop_pkg::LS_J;
    tick(IDLE_N - 6);
    rd(4'h8, 32'h0000_0020);
    tick(10);
    rd(4'h8, 32'h0000_0030);
    $display("test idle and resume done");
    finish_test();
  end

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule

bind uop_regs uop_regs_assertions chk_u (.clk_sys, .nrst, .clkEn,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .hwDplusPullup,
  .tokenFifoAdvance, .dplusPullupOn, .dminusPullupOn, .dplusPulldownOn,
  .dminusPulldownOn, .supplyPowerOn, .supplyChargeOn, .supplyDischargeOn,
  .usbClkRun, .xcvrLowPower);
`default_nettype wire
